// ### bench/test_user_break_condition_matcher.sv
/*
 test_user_break_condition_matcher: both matcher ends joined by the
 link and driven over apb. Assumes CYC and DEVW take ARGA and ARGD.
*/
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module test_user_break_condition_matcher;
  import ubm_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pend;
  logic [3:0] flags;
  logic [31:0] q;
  logic e;
  logic [31:0] ctl = 32'h0000_0000;
  logic [7:0] cnt;
  logic [1:0] szs [5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
  logic [31:0] ads [5] = '{32'h0000_1000, 32'h0000_1000, 32'h0000_1002,
                           32'h0000_1002, 32'h0000_1003};
  logic [31:0] exs [5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1};
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  ubm_if i_ubm_if();
  ubm_matcher_dev i_ubm_matcher_dev(.i_clk_sys(clk), .i_resetn(resetn),
    .bus(i_ubm_if.dev), .o_break_pending(pend), .o_match_flags(flags));
  ubm_cpu_end i_ubm_cpu_end(.i_clk_sys(clk), .i_resetn(resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .bus(i_ubm_if.cpu));
  ubm_link_sva i_ubm_link_sva(.i_clk_sys(clk), .i_resetn(resetn),
    .reg_rd(i_ubm_if.reg_rd), .reg_rvalid(i_ubm_if.reg_rvalid),
    .lb_valid(i_ubm_if.lb_valid), .lb(i_ubm_if.lb),
    .ib_valid(i_ubm_if.ib_valid), .ib(i_ubm_if.ib),
    .brk_req(i_ubm_if.brk_req), .brk_kind(i_ubm_if.brk_kind),
    .brk_ack(i_ubm_if.brk_ack));
  always #12.5 clk = ~clk;
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // tests take under two thousand cycles; generous ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // entered right after a rising edge; pready seen as sampled there
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic dw(input logic [3:0] ix, input logic [31:0] v);
    apb(1'b1, `UBM_HA_ARGA, {28'h000_0000, ix});
    apb(1'b1, `UBM_HA_ARGD, v);
    apb(1'b1, `UBM_HA_DEVW, 32'h0000_0000);
  endtask
  task automatic dr(input logic [3:0] ix);
    apb(1'b1, `UBM_HA_ARGA, {28'h000_0000, ix});
    apb(1'b0, `UBM_HA_DEVR, 32'h0000_0000);
  endtask
  // clear flags, issue one bus cycle, let flags settle
  task automatic hit(input logic [31:0] w, input logic [31:0] a,
                     input logic [31:0] d);
    dw(`UBM_IX_CTRL, ctl);
    apb(1'b1, `UBM_HA_ARGA, a);
    apb(1'b1, `UBM_HA_ARGD, d);
    apb(1'b1, `UBM_HA_CYC, w);
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] cw(input logic [1:0] sz,
      input logic [2:0] src, input logic loc, input logic fet);
    cw = 32'h0000_0000;
    cw[`UBM_CY_SZ] = sz;
    cw[`UBM_CY_SRC] = src;
    cw[`UBM_CY_LOC] = loc;
    cw[`UBM_CY_FET] = fet;
    cw[`UBM_CY_CONF] = fet;
  endfunction
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({27'h000_0000, pend, flags}, 32'h0000_0000);
    apb(1'b0, 12'h01c, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b1, `UBM_HA_CPU, 32'h0000_0002);
    dw(`UBM_IX_CC_A, 32'h0000_ffff);
    dr(`UBM_IX_CC_A);
    chk(q, 32'h0000_00ff);
    dw(`UBM_IX_ADDR_A, 32'h0000_1003);
    dw(`UBM_IX_AMSK_A, 32'h0000_0000);
    for (int g = 0; g < 3; g++) begin
      dw(`UBM_IX_CC_A, 32'h0000_0039 & ~(32'h0000_0003 << (2 * g)));
      hit(cw(2'h1, 3'h0, 1'b1, 1'b0), 32'h0000_1003, 32'h0000_0000);
      chk({28'h000_0000, flags}, 32'h0000_0000);
    end
    dw(`UBM_IX_CC_A, 32'h0000_0039);
    for (int i = 0; i < 5; i++) begin
      hit(cw(szs[i], 3'h0, 1'b1, 1'b0), ads[i], 32'h0000_0000);
      chk({28'h000_0000, flags}, exs[i]);
    end
    apb(1'b1, `UBM_HA_ARGA, 32'h0000_2000);
    apb(1'b1, `UBM_HA_CYC, cw(2'h1, 3'h0, 1'b1, 1'b0));
    repeat (3) @(posedge clk);
    dw(`UBM_IX_CTRL, 32'h0000_00f0);
    chk({28'h000_0000, flags}, 32'h0000_0001);
    apb(1'b1, `UBM_HA_CPU, 32'h0000_0003);
    hit(cw(2'h1, 3'h0, 1'b1, 1'b0), 32'h0000_1003, 32'h0000_0000);
    repeat (5) @(posedge clk);
    chk({27'h000_0000, pend, flags}, 32'h0000_0011);
    apb(1'b1, `UBM_HA_CPU, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk({31'h0000_0000, pend}, 32'h0000_0000);
    dw(`UBM_IX_ADDR_B, 32'h0000_1003);
    dw(`UBM_IX_AMSK_B, 32'h0000_0000);
    dw(`UBM_IX_CC_B, 32'h0000_0019);
    apb(1'b0, `UBM_HA_STAT, 32'h0000_0000);
    cnt = q[15:8] + 8'h01;
    hit(cw(2'h1, 3'h0, 1'b1, 1'b0), 32'h0000_1003, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0003);
    apb(1'b0, `UBM_HA_STAT, 32'h0000_0000);
    chk({24'h00_0000, q[15:8]}, {24'h00_0000, cnt});
    dw(`UBM_IX_CC_A, 32'h0000_0000);
    dw(`UBM_IX_DATA_B, 32'h0000_1234);
    dw(`UBM_IX_DMSK_B, 32'h0000_0000);
    dw(`UBM_IX_CC_B, 32'h0000_0199);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b0), 32'h0000_1002, 32'habcd_1234);
    chk({28'h000_0000, flags}, 32'h0000_0002);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b0), 32'h0000_1002, 32'h0000_1235);
    chk({28'h000_0000, flags}, 32'h0000_0000);
    dw(`UBM_IX_CC_B, 32'h0000_0000);
    dw(`UBM_IX_CC_A, 32'h0000_001a);
    hit(cw(2'h1, 3'h6, 1'b0, 1'b0), 32'h0000_1003, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0004);
    dw(`UBM_IX_ADDR_A, 32'h0000_2000);
    dw(`UBM_IX_CC_A, 32'h0000_00d6);
    hit(cw(2'h2, 3'h1, 1'b0, 1'b1), 32'h0000_2002, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0004);
    hit(cw(2'h3, 3'h6, 1'b0, 1'b0), 32'h0000_2000, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0000);
    dw(`UBM_IX_ADDR_A, 32'h0000_3001);
    dw(`UBM_IX_CC_A, 32'h0000_0015);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b1), 32'h0000_3001, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0000);
    dw(`UBM_IX_ADDR_A, 32'h0000_3000);
    dw(`UBM_IX_CC_A, 32'h0000_0015);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b1) & ~(32'h0000_0001 << `UBM_CY_CONF),
        32'h0000_3000, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0000);
    ctl = 32'h0000_0001;
    hit(cw(2'h2, 3'h0, 1'b1, 1'b1), 32'h0000_3000, 32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0001);
    apb(1'b0, `UBM_HA_STAT, 32'h0000_0000);
    chk({30'h0000_0000, q[2:1]}, 32'h0000_0002);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b1) | 32'h0000_0400, 32'h0000_3000,
        32'h0000_0000);
    apb(1'b0, `UBM_HA_STAT, 32'h0000_0000);
    chk({30'h0000_0000, q[2:1]}, 32'h0000_0003);
    ctl = 32'h0000_0000;
    hit(cw(2'h2, 3'h0, 1'b1, 1'b1) | 32'h0000_0200, 32'h0000_3000,
        32'h0000_0000);
    apb(1'b0, `UBM_HA_STAT, 32'h0000_0000);
    chk({30'h0000_0000, q[2:1]}, 32'h0000_0001);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b1), 32'h0000_3000, 32'h0000_0000);
    apb(1'b0, `UBM_HA_STAT, 32'h0000_0000);
    chk({30'h0000_0000, q[2:1]}, 32'h0000_0000);
    dw(`UBM_IX_CC_B, 32'h0000_01d9);
    hit(cw(2'h3, 3'h0, 1'b1, 1'b0) | 32'h0000_0800, 32'h0000_1000,
        32'h0000_1234);
    chk({28'h000_0000, flags}, 32'h0000_0000);
    dw(`UBM_IX_CC_B, 32'h0000_0199);
    hit(cw(2'h2, 3'h0, 1'b1, 1'b0) | 32'h0000_1000, 32'h0000_1002,
        32'h0000_5678);
    chk({28'h000_0000, flags}, 32'h0000_0002);
    dw(`UBM_IX_CC_B, 32'h0000_0219);
    hit(cw(2'h1, 3'h0, 1'b1, 1'b0) | 32'h0000_2000, 32'h0000_1003,
        32'h0000_0000);
    chk({28'h000_0000, flags}, 32'h0000_0002);
    close_out;
  end
endmodule // test_user_break_condition_matcher

// ### bench/ubm_link_sva.sv
/*
 ubm_link_sva: checks on the signals of the matcher link.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ubm_link_sva
  import ubm_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_resetn, // sync reset, active low
  input wire logic reg_rd, // register read
  input wire logic reg_rvalid, // read answer
  input wire logic lb_valid, // local bus cycle
  input wire ubm_cyc_t lb, // local cycle body
  input wire logic ib_valid, // internal bus cycle
  input wire ubm_cyc_t ib, // internal cycle body
  input wire logic brk_req, // break request
  input wire ubm_kind_t brk_kind, // break timing kind
  input wire logic brk_ack // break accepted
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  AST_RD_ANSWER:
    assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  AST_RD_ONLY:
    assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  AST_REQ_HOLD:
    assert property (brk_req && !brk_ack |=> brk_req && $stable(brk_kind))
    else $error("request changed before accept");
  AST_REQ_DROP:
    assert property (brk_ack && !lb_valid && !ib_valid |=> !brk_req)
    else $error("request kept after accept");
  AST_REQ_CAUSE:
    assert property ($rose(brk_req) |-> $past(lb_valid) || $past(ib_valid))
    else $error("request without bus cycle");
  AST_ACK_REQ:
    assert property (brk_ack |-> brk_req)
    else $error("accept without request");
  AST_IB_KIND:
    assert property ($rose(brk_req) && !$past(lb_valid) |->
      brk_kind == UBM_K_AFTER)
    else $error("internal bus break kind wrong");
  AST_IB_FETCH_LONG:
    assert property (ib_valid && ib.fetch |->
      ib.size == 2'h3 && ib.addr[1:0] == 2'h0)
    else $error("internal fetch not long aligned");
  AST_NO_UNCONF:
    assert property (lb_valid && lb.fetch && !lb.conf && !ib_valid &&
      !brk_req |=> !brk_req)
    else $error("break on unconfirmed fetch");
  // ack with a fresh match in the same edge is legal, so not covered here
  cover property ($rose(brk_req));
  cover property (brk_ack);
  cover property (ib_valid && ib.fetch);
  cover property (reg_rvalid);
endmodule // ubm_link_sva

// ### rtl/ubm_cfg.svh
/*
 ubm_cfg.svh: register indices, field positions, codes and host map
 of the user break matcher. Assumes nothing; definitions only.
*/
`ifndef UBM_CFG_SVH
`define UBM_CFG_SVH
`define UBM_IX_ADDR_A 4'h0
`define UBM_IX_ADDR_B 4'h1
`define UBM_IX_AMSK_A 4'h2
`define UBM_IX_AMSK_B 4'h3
`define UBM_IX_DATA_B 4'h4
`define UBM_IX_DMSK_B 4'h5
`define UBM_IX_CC_A 4'h6
`define UBM_IX_CC_B 4'h7
`define UBM_IX_CTRL 4'h8
`define UBM_CC_BUS 1:0
`define UBM_CC_FD 3:2
`define UBM_CC_RW 5:4
`define UBM_CC_SZ 7:6
`define UBM_CC_DAT 8
`define UBM_CC_XY 9
`define UBM_CC_MSK_A 16'h00ff
`define UBM_CC_MSK_B 16'h03ff
`define UBM_GRP_OFF 2'h0
`define UBM_BC_AFT_A 0
`define UBM_BC_AFT_B 1
`define UBM_BC_FLG 7:4
`define UBM_SZ_NONE 2'h0
`define UBM_SZ_LONG 2'h3
`define UBM_SZ_WORD 2'h2
`define UBM_IGN_LONG 32'h0000_0003
`define UBM_IGN_WORD 32'h0000_0001
`define UBM_IGN_BYTE 32'h0000_0000
`define UBM_ALIGN_L 32'hffff_fffc
`define UBM_ZERO32 32'h0000_0000
`define UBM_HA_ARGA 12'h000
`define UBM_HA_ARGD 12'h004
`define UBM_HA_CYC 12'h008
`define UBM_HA_DEVW 12'h00c
`define UBM_HA_DEVR 12'h010
`define UBM_HA_CPU 12'h014
`define UBM_HA_STAT 12'h018
`define UBM_CY_SZ 1:0
`define UBM_CY_SRC 4:2
`define UBM_CY_WR 5
`define UBM_CY_LOC 6
`define UBM_CY_FET 7
`define UBM_CY_CONF 8
`define UBM_CY_DSL 9
`define UBM_CY_DBR 10
`define UBM_CY_PREFETCH_INSTRUCTION 11
`define UBM_CY_DSPW 12
`define UBM_CY_XY 13
`define UBM_CPU_BLK 0
`define UBM_CPU_ACK 1
`endif

// ### rtl/ubm_chan_cmp.sv
/*
 ubm_chan_cmp: one channel compared against one bus, combinational.
 Assumes registers are stable and the cycle is valid with i_valid.
*/
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module ubm_chan_cmp
  import ubm_pkg::*;
#(
  parameter bit HAS_DATA = 1'b0,
  parameter bit LOCAL = 1'b1
) (
  input wire logic [15:0] i_cc, // cycle condition
  input wire logic [31:0] i_addr, // break address
  input wire logic [31:0] i_amask, // address mask, 1 ignores
  input wire logic [31:0] i_data, // break data
  input wire logic [31:0] i_dmask, // data mask, 1 ignores
  input wire logic i_valid, // bus cycle present
  input wire ubm_cyc_t i_cyc, // bus cycle
  output logic o_hit // all conditions met
);
  function automatic logic [31:0] ign_of(input logic [1:0] sz);
    case (sz)
      `UBM_SZ_LONG: ign_of = `UBM_IGN_LONG;
      `UBM_SZ_WORD: ign_of = `UBM_IGN_WORD;
      default: ign_of = `UBM_IGN_BYTE;
    endcase
  endfunction

  function automatic logic dat_eq(input ubm_cyc_t c,
                                  input logic [31:0] d,
                                  input logic [31:0] m);
    logic [31:0] x;
    x = (c.data ^ d) & ~m;
    if (c.dspw) begin
      dat_eq = (x[31:16] == 16'h0000);
    end else if (c.size == `UBM_SZ_LONG) begin
      dat_eq = (x == `UBM_ZERO32);
    end else begin
      dat_eq = (x[15:0] == 16'h0000);
    end
  endfunction

  logic [1:0] bsel, fsel, wsel, csz;
  logic grp_on, bus_ok, fd_ok, rw_ok, sz_ok, adr_ok;
  logic lsb_ok, exe_ok, use_dat, dat_ok, xy_ok;
  assign bsel = i_cc[`UBM_CC_BUS];
  assign fsel = i_cc[`UBM_CC_FD];
  assign wsel = i_cc[`UBM_CC_RW];
  assign csz = i_cc[`UBM_CC_SZ];
  assign grp_on = (bsel != `UBM_GRP_OFF) && (fsel != `UBM_GRP_OFF)
                  && (wsel != `UBM_GRP_OFF);
  assign bus_ok = LOCAL ? bsel[0] : bsel[1];
  assign fd_ok = i_cyc.fetch ? fsel[0] : fsel[1];
  assign rw_ok = i_cyc.write ? wsel[1] : wsel[0];
  assign sz_ok = (csz == `UBM_SZ_NONE) || (csz == i_cyc.size);
  // masked address, low bits dropped per access size
  assign adr_ok = ((i_cyc.addr ^ i_addr)
                   & ~(i_amask | ign_of(i_cyc.size)))
                  == `UBM_ZERO32;
  assign lsb_ok = !(i_cyc.fetch && i_addr[0]);
  // overrun fetches on the local bus never break
  assign exe_ok = !(LOCAL && i_cyc.fetch && !i_cyc.conf);
  assign use_dat = HAS_DATA && i_cc[`UBM_CC_DAT] && !i_cyc.fetch;
  assign dat_ok = !use_dat || ((csz != `UBM_SZ_NONE) && !i_cyc.prefetch_instruction
                  && dat_eq(i_cyc, i_data, i_dmask));
  assign xy_ok = LOCAL ? (i_cc[`UBM_CC_XY] == i_cyc.xy)
                       : !i_cc[`UBM_CC_XY];
  assign o_hit = i_valid && grp_on && bus_ok && fd_ok && rw_ok
                 && sz_ok && adr_ok && lsb_ok && exe_ok && dat_ok
                 && xy_ok;
endmodule // ubm_chan_cmp

// ### rtl/ubm_cpu_end.sv
/*
 ubm_cpu_end: cpu and bus-master side of the matcher link.
 Takes orders over apb, programs the matcher, issues local and
 internal bus cycles and accepts break requests.
 Assumes an apb master on the same clock.
*/
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module ubm_cpu_end
  import ubm_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_resetn, // sync reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb write
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped
  ubm_if.cpu bus // matcher link
);
  typedef struct packed {
    logic [31:0] arg_a;
    logic [31:0] arg_d;
    logic blk;
    logic auto_ack;
    logic lb_v;
    logic ib_v;
    ubm_cyc_t lb;
    ubm_cyc_t ib;
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [31:0] wd;
    logic ack;
    logic [7:0] cnt;
    ubm_kind_t last;
    ubm_apb_st_t st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ubm_cpu_st_t;

  ubm_cpu_st_t r, n;

  // shape a cpu or dma request as it appears on the internal bus
  function automatic ubm_cyc_t ib_of(input ubm_cyc_t c,
                                      input ubm_src_t s);
    ib_of = c;
    ib_of.fetch = 1'b0;
    ib_of.conf = 1'b0;
    ib_of.dslot = 1'b0;
    ib_of.dbr = 1'b0;
    ib_of.xy = 1'b0;
    case (s)
      UBM_SRC_UNC_FETCH, UBM_SRC_FILL_FETCH: begin
        ib_of.size = `UBM_SZ_LONG;
        ib_of.addr = c.addr & `UBM_ALIGN_L;
        ib_of.fetch = 1'b1;
        ib_of.write = 1'b0;
      end
      UBM_SRC_FILL_DATA, UBM_SRC_WBACK: begin
        ib_of.size = `UBM_SZ_LONG;
        ib_of.addr = c.addr & `UBM_ALIGN_L;
        ib_of.write = (s == UBM_SRC_WBACK);
      end
      UBM_SRC_WT_MISS: ib_of.write = 1'b1;
      default: ib_of.size = c.size;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `UBM_HA_ARGA) || (a == `UBM_HA_ARGD)
             || (a == `UBM_HA_CYC) || (a == `UBM_HA_DEVW)
             || (a == `UBM_HA_DEVR) || (a == `UBM_HA_CPU)
             || (a == `UBM_HA_STAT);
  endfunction

  ubm_cyc_t cyc;
  always_comb begin
    cyc.addr = r.arg_a;
    cyc.data = r.arg_d;
    cyc.size = i_pwdata[`UBM_CY_SZ];
    cyc.write = i_pwdata[`UBM_CY_WR];
    cyc.fetch = i_pwdata[`UBM_CY_FET];
    cyc.conf = i_pwdata[`UBM_CY_CONF];
    cyc.dslot = i_pwdata[`UBM_CY_DSL];
    cyc.dbr = i_pwdata[`UBM_CY_DBR];
    cyc.prefetch_instruction = i_pwdata[`UBM_CY_PREFETCH_INSTRUCTION];
    cyc.dspw = i_pwdata[`UBM_CY_DSPW];
    cyc.xy = i_pwdata[`UBM_CY_XY];
  end

  always_comb begin
    n = r;
    n.lb_v = 1'b0;
    n.ib_v = 1'b0;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.ack = 1'b0;
    case (r.st)
      UBM_S_IDLE: begin
        if (i_psel && i_penable) begin
          if (!i_pwrite && i_paddr == `UBM_HA_DEVR) begin
            n.rd = 1'b1;
            n.idx = r.arg_a[3:0];
            n.st = UBM_S_WAIT;
          end else begin
            case (i_paddr)
              `UBM_HA_ARGA: n.prdata = r.arg_a;
              `UBM_HA_ARGD: n.prdata = r.arg_d;
              `UBM_HA_CPU: n.prdata = {30'h0000_0000, r.auto_ack, r.blk};
              `UBM_HA_STAT: n.prdata = {16'h0000, r.cnt, 5'h00, r.last,
                                        bus.brk_req};
              default: n.prdata = `UBM_ZERO32;
            endcase
            n.pslverr = !mapped(i_paddr);
            n.pready = 1'b1;
            n.st = UBM_S_RESP;
          end
        end
      end
      UBM_S_WAIT: begin
        if (bus.reg_rvalid) begin
          n.prdata = bus.reg_rdata;
          n.pslverr = 1'b0;
          n.pready = 1'b1;
          n.st = UBM_S_RESP;
        end
      end
      UBM_S_RESP: begin
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.st = UBM_S_IDLE;
        // writes land on the edge that completes the transfer
        if (i_psel && i_penable && i_pwrite) begin
          case (i_paddr)
            `UBM_HA_ARGA: n.arg_a = i_pwdata;
            `UBM_HA_ARGD: n.arg_d = i_pwdata;
            `UBM_HA_DEVW: begin
              n.wr = 1'b1;
              n.idx = r.arg_a[3:0];
              n.wd = r.arg_d;
            end
            `UBM_HA_CPU: begin
              n.blk = i_pwdata[`UBM_CPU_BLK];
              n.auto_ack = i_pwdata[`UBM_CPU_ACK];
            end
            `UBM_HA_CYC: begin
              if (i_pwdata[`UBM_CY_LOC]) begin
                n.lb_v = 1'b1;
                n.lb = cyc;
              end else begin
                n.ib_v = 1'b1;
                n.ib = ib_of(cyc, ubm_src_t'(i_pwdata[`UBM_CY_SRC]));
              end
            end
            default: n.arg_a = r.arg_a;
          endcase
        end
      end
      default: n.st = UBM_S_IDLE;
    endcase
    // accept only while unblocked; the request waits otherwise
    if (bus.brk_req && !r.ack && !r.blk && r.auto_ack) begin
      n.ack = 1'b1;
      n.cnt = r.cnt + 8'h01;
      n.last = bus.brk_kind;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_prdata = r.prdata;
  assign o_pready = r.pready;
  assign o_pslverr = r.pslverr;
  assign bus.reg_wr = r.wr;
  assign bus.reg_rd = r.rd;
  assign bus.reg_idx = r.idx;
  assign bus.reg_wdata = r.wd;
  assign bus.lb_valid = r.lb_v;
  assign bus.lb = r.lb;
  assign bus.ib_valid = r.ib_v;
  assign bus.ib = r.ib;
  assign bus.brk_ack = r.ack;
endmodule // ubm_cpu_end

// ### rtl/ubm_if.sv
/*
 ubm_if: link between the break matcher and the cpu/bus side.
 Assumes both ends share one clock; all signals are synchronous.
*/
`timescale 1ns/1ps
interface ubm_if;
  import ubm_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_idx;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic lb_valid;
  ubm_cyc_t lb;
  logic ib_valid;
  ubm_cyc_t ib;
  logic brk_req;
  ubm_kind_t brk_kind;
  logic brk_ack;
  modport dev (
    input reg_wr, reg_rd, reg_idx, reg_wdata, lb_valid, lb,
    input ib_valid, ib, brk_ack,
    output reg_rdata, reg_rvalid, brk_req, brk_kind
  );
  modport cpu (
    output reg_wr, reg_rd, reg_idx, reg_wdata, lb_valid, lb,
    output ib_valid, ib, brk_ack,
    input reg_rdata, reg_rvalid, brk_req, brk_kind
  );
endinterface

// ### rtl/ubm_matcher_dev.sv
/*
 ubm_matcher_dev: two-channel user break matcher, device end.
 Holds the break registers, watches the local and internal bus,
 raises one break request and sticky match flags.
 Assumes the cpu end drives bus cycles and break acceptance.
*/
`timescale 1ns/1ps
`include "ubm_cfg.svh"
module ubm_matcher_dev
  import ubm_pkg::*;
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_resetn, // sync reset, active low
  ubm_if.dev bus, // cpu/bus side link
  output logic o_break_pending, // break request outstanding
  output logic [3:0] o_match_flags // lm_a lm_b im_a im_b
);
  typedef struct packed {
    logic [31:0] addr_a;
    logic [31:0] addr_b;
    logic [31:0] amsk_a;
    logic [31:0] amsk_b;
    logic [31:0] data_b;
    logic [31:0] dmsk_b;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic aft_a;
    logic aft_b;
    logic [3:0] flg;
    logic req;
    ubm_kind_t kind;
    logic [31:0] rdata;
    logic rvalid;
    logic pend;
    logic [3:0] flg_out;
  } ubm_dev_st_t;

  ubm_dev_st_t r, n;
  logic [3:0] hit;
  logic [31:0] baddr [2];
  logic [31:0] bamsk [2];
  logic [15:0] bcc [2];

  assign baddr[0] = r.addr_a;
  assign baddr[1] = r.addr_b;
  assign bamsk[0] = r.amsk_a;
  assign bamsk[1] = r.amsk_b;
  assign bcc[0] = r.cc_a;
  assign bcc[1] = r.cc_b;

  // hit index: {bus, channel}; bus 0 local, 1 internal
  for (genvar bs = 0; bs < 2; bs++) begin : g_bus
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      ubm_chan_cmp #(
        .HAS_DATA(ch == 1),
        .LOCAL(bs == 0)
      ) u_cmp (
        .i_cc(bcc[ch]),
        .i_addr(baddr[ch]),
        .i_amask(bamsk[ch]),
        .i_data(r.data_b),
        .i_dmask(r.dmsk_b),
        .i_valid(bs == 0 ? bus.lb_valid : bus.ib_valid),
        .i_cyc(bs == 0 ? bus.lb : bus.ib),
        .o_hit(hit[bs*2+ch])
      );
    end
  end

  // break timing for a local-bus match
  function automatic ubm_kind_t kind_of(input logic aft,
                                        input ubm_cyc_t c);
    if (!c.fetch) begin
      kind_of = UBM_K_AFTER;
    end else if (aft) begin
      // branch and its slot both run; stop at the target
      kind_of = (c.dbr || c.dslot) ? UBM_K_TARGET
                                   : UBM_K_AFTER;
    end else begin
      // cpu drops dslot on an untaken conditional branch
      kind_of = c.dslot ? UBM_K_BEF_BR : UBM_K_BEFORE;
    end
  endfunction

  function automatic logic [31:0] rd_mux(input ubm_dev_st_t s,
                                          input logic [3:0] ix);
    case (ix)
      `UBM_IX_ADDR_A: rd_mux = s.addr_a;
      `UBM_IX_ADDR_B: rd_mux = s.addr_b;
      `UBM_IX_AMSK_A: rd_mux = s.amsk_a;
      `UBM_IX_AMSK_B: rd_mux = s.amsk_b;
      `UBM_IX_DATA_B: rd_mux = s.data_b;
      `UBM_IX_DMSK_B: rd_mux = s.dmsk_b;
      `UBM_IX_CC_A: rd_mux = {16'h0000, s.cc_a};
      `UBM_IX_CC_B: rd_mux = {16'h0000, s.cc_b};
      `UBM_IX_CTRL: begin
        rd_mux = `UBM_ZERO32;
        rd_mux[`UBM_BC_AFT_A] = s.aft_a;
        rd_mux[`UBM_BC_AFT_B] = s.aft_b;
        rd_mux[`UBM_BC_FLG] = s.flg;
      end
      default: rd_mux = `UBM_ZERO32;
    endcase
  endfunction

  always_comb begin
    n = r;
    n.rvalid = 1'b0;
    if (bus.brk_ack) begin
      n.req = 1'b0;
    end
    if (bus.reg_wr) begin
      case (bus.reg_idx)
        `UBM_IX_ADDR_A: n.addr_a = bus.reg_wdata;
        `UBM_IX_ADDR_B: n.addr_b = bus.reg_wdata;
        `UBM_IX_AMSK_A: n.amsk_a = bus.reg_wdata;
        `UBM_IX_AMSK_B: n.amsk_b = bus.reg_wdata;
        `UBM_IX_DATA_B: n.data_b = bus.reg_wdata;
        `UBM_IX_DMSK_B: n.dmsk_b = bus.reg_wdata;
        // channel armed as soon as this lands
        `UBM_IX_CC_A: begin
          n.cc_a = bus.reg_wdata[15:0] & `UBM_CC_MSK_A;
        end
        `UBM_IX_CC_B: begin
          n.cc_b = bus.reg_wdata[15:0] & `UBM_CC_MSK_B;
        end
        `UBM_IX_CTRL: begin
          n.aft_a = bus.reg_wdata[`UBM_BC_AFT_A];
          n.aft_b = bus.reg_wdata[`UBM_BC_AFT_B];
          // writing 1 keeps a flag, writing 0 clears it
          n.flg = r.flg & bus.reg_wdata[`UBM_BC_FLG];
        end
        default: n.flg = n.flg;
      endcase
    end
    if (bus.reg_rd) begin
      n.rvalid = 1'b1;
      n.rdata = rd_mux(r, bus.reg_idx);
    end
    // set after clear: a match in the clearing cycle survives
    n.flg = n.flg | hit;
    // a pending request absorbs further matches
    if ((hit != 4'h0) && !n.req) begin
      n.req = 1'b1;
      if (hit[0]) begin
        n.kind = kind_of(r.aft_a, bus.lb);
      end else if (hit[1]) begin
        n.kind = kind_of(r.aft_b, bus.lb);
      end else begin
        // internal bus cannot pin the instruction down
        n.kind = UBM_K_AFTER;
      end
    end
    n.pend = n.req;
    n.flg_out = n.flg;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bus.reg_rdata = r.rdata;
  assign bus.reg_rvalid = r.rvalid;
  assign bus.brk_req = r.req;
  assign bus.brk_kind = r.kind;
  assign o_break_pending = r.pend;
  assign o_match_flags = r.flg_out;
endmodule // ubm_matcher_dev

// ### rtl/ubm_pkg.sv
/*
 ubm_pkg: types shared by both ends of the user break matcher.
 Assumes ubm_cfg.svh for the numeric constants.
*/
package ubm_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0] size;
    logic write;
    logic fetch;
    logic conf;
    logic dslot;
    logic dbr;
    logic prefetch_instruction;
    logic dspw;
    logic xy;
  } ubm_cyc_t;
  typedef enum logic [1:0] {
    UBM_K_BEFORE = 2'b00,
    UBM_K_BEF_BR = 2'b01,
    UBM_K_AFTER = 2'b10,
    UBM_K_TARGET = 2'b11
  } ubm_kind_t;
  typedef enum logic [2:0] {
    UBM_SRC_UNC_DATA = 3'b000,
    UBM_SRC_UNC_FETCH = 3'b001,
    UBM_SRC_FILL_FETCH = 3'b010,
    UBM_SRC_FILL_DATA = 3'b011,
    UBM_SRC_WBACK = 3'b100,
    UBM_SRC_WT_MISS = 3'b101,
    UBM_SRC_DMA = 3'b110
  } ubm_src_t;
  typedef enum logic [1:0] {
    UBM_S_IDLE = 2'b00,
    UBM_S_WAIT = 2'b01,
    UBM_S_RESP = 2'b10
  } ubm_apb_st_t;
endpackage
